/* hdl/clock_gen.sv */
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module clock_gen
    import clock_gen_pkg::*;
#(
    parameter logic [7:0] LOCK_T = LOCK_TOL,
    parameter logic [7:0] UNLOCK_T = UNLOCK_TOL,
    parameter logic [7:0] TRACK_T = TRACK_TOL,
    parameter logic [7:0] UNTRACK_T = UNTRACK_TOL
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // source clocks and stop request, sampled as levels
    input wire logic crystal_clock,
    input wire logic vco_clock,
    input wire logic stop_req,
    // clock outputs and switch busy flag
    output logic base_clock_out,
    output logic bus_clock_out,
    output logic switch_busy,
    // loop controls to the analog part
    output logic loop_enable,
    output logic filter_track,
    output logic [3:0] feedback_mult,
    output logic [3:0] range_mult,
    // lock interrupt
    output logic loop_irq
);
    top_reg_t s_reg;
    top_reg_t s_next;
    lock_status_t status;
    logic x_edge;
    logic v_edge;

    function automatic logic [7:0] read_mux(input top_reg_t s, input lock_status_t st,
                                            input logic [7:0] adr);
        read_mux = 8'h00;
        if (adr == ADR_CTRL)
        begin
            read_mux[CTRL_IE_BIT] = s.ie & s.auto_bw;
            read_mux[CTRL_FLAG_BIT] = s.flag & s.auto_bw;
            read_mux[CTRL_ON_BIT] = s.on;
            read_mux[CTRL_SEL_BIT] = s.sel;
            read_mux[3:0] = CTRL_UNUSED;
        end
        else if (adr == ADR_BW)
        begin
            read_mux[BW_AUTO_BIT] = s.auto_bw;
            read_mux[BW_LOCK_BIT] = st.lock & s.auto_bw;
            read_mux[BW_TRACK_BIT] = s.auto_bw ? st.track : s.acq_man;
        end
        else if (adr == ADR_DIV)
            read_mux = s.div;
    endfunction

    assign x_edge = crystal_clock & !s_reg.xprev;
    assign v_edge = vco_clock & !s_reg.vprev;

    always_comb
    begin
        logic access;
        logic wr;
        logic rd;
        logic [7:0] d;
        logic range_zero;
        logic [3:0] mult;
        s_next = s_reg;
        range_zero = 1'b0;
        mult = 4'h0;
        access = wb_cyc_i & wb_stb_i & !s_reg.ack;
        wr = access & wb_we_i & wb_sel_i[0];
        rd = access & !wb_we_i;
        d = wb_dat_i[7:0];
        s_next.ack = access;
        s_next.xprev = crystal_clock;
        s_next.vprev = vco_clock;
        if (access)
            s_next.dat = wb_we_i ? 8'h00 : read_mux(s_reg, status, wb_adr_i);

        // register writes
        if (wr && wb_adr_i == ADR_CTRL)
        begin
            if (s_reg.auto_bw)
                s_next.ie = d[CTRL_IE_BIT];
            // both checks use the old values: setting both from off moves only on, clearing both moves only sel
            if (!(s_reg.sel && !d[CTRL_ON_BIT]))
                s_next.on = d[CTRL_ON_BIT];
            if (!(d[CTRL_SEL_BIT] && (!s_reg.on || s_reg.div[3:0] == 4'h0)))
                s_next.sel = d[CTRL_SEL_BIT];
        end
        if (wr && wb_adr_i == ADR_BW)
        begin
            s_next.auto_bw = d[BW_AUTO_BIT];
            // manual track value kept while auto runs
            if (!s_reg.auto_bw)
                s_next.acq_man = d[BW_TRACK_BIT];
        end
        if (wr && wb_adr_i == ADR_DIV)
            s_next.div = d;

        range_zero = (s_next.div[3:0] == 4'h0);
        if (range_zero || stop_req)
            s_next.sel = 1'b0;

        // lock change flag: set wins over the read clear
        s_next.lock_prev = status.lock;
        if (rd && wb_adr_i == ADR_CTRL)
            s_next.flag = 1'b0;
        if (s_reg.auto_bw && status.lock != s_reg.lock_prev)
            s_next.flag = 1'b1;
        if (!s_reg.auto_bw)
            s_next.flag = 1'b0;

        mult = s_next.div[7:MULT_LSB];
        s_next.mult_eff = (mult == 4'h0) ? 4'h1 : mult;
        s_next.loop_en = s_next.on && !range_zero;
        s_next.filt_track = s_reg.auto_bw ? status.track : s_reg.acq_man;
        s_next.irq = s_reg.auto_bw & s_reg.ie & s_reg.flag;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.on <= CTRL_ON_RESET;
            s_reg.div <= DIV_RESET;
            s_reg.mult_eff <= DIV_RESET[7:MULT_LSB];
            s_reg.loop_en <= CTRL_ON_RESET;
        end
        else
            s_reg <= s_next;
    end

    lock_compare #(
        .LOCK_T(LOCK_T),
        .UNLOCK_T(UNLOCK_T),
        .TRACK_T(TRACK_T),
        .UNTRACK_T(UNTRACK_T)
    ) u_cmp (
        .clk(clk),
        .rst_n(rst_n),
        .enable(s_reg.loop_en),
        .mult(s_reg.mult_eff),
        .ref_edge(x_edge),
        .fb_edge(v_edge),
        .status(status)
    );

    clock_switch u_sw (
        .clk(clk),
        .rst_n(rst_n),
        .x_edge(x_edge),
        .v_edge(v_edge),
        .want_vco(s_reg.sel & s_reg.loop_en),
        .vco_running(s_reg.loop_en),
        .base_out(base_clock_out),
        .bus_out(bus_clock_out),
        .busy(switch_busy)
    );

    assign wb_dat_o = {24'h000000, s_reg.dat};
    assign wb_ack_o = s_reg.ack;
    assign loop_enable = s_reg.loop_en;
    assign filter_track = s_reg.filt_track;
    assign feedback_mult = s_reg.mult_eff;
    assign range_mult = s_reg.div[3:0];
    assign loop_irq = s_reg.irq;
endmodule
`default_nettype wire

/* hdl/clock_gen_pkg.sv */
package clock_gen_pkg;

    // register indices and byte addresses
    localparam logic [7:0] IDX_CTRL = 8'h1C;
    localparam logic [7:0] IDX_BW = 8'h1D;
    localparam logic [7:0] IDX_DIV = 8'h1E;
    localparam logic [7:0] ADR_CTRL = {IDX_CTRL[5:0], 2'b00};
    localparam logic [7:0] ADR_BW = {IDX_BW[5:0], 2'b00};
    localparam logic [7:0] ADR_DIV = {IDX_DIV[5:0], 2'b00};

    // field positions
    localparam int CTRL_IE_BIT = 7;
    localparam int CTRL_FLAG_BIT = 6;
    localparam int CTRL_ON_BIT = 5;
    localparam int CTRL_SEL_BIT = 4;
    localparam logic [3:0] CTRL_UNUSED = 4'hF;
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_LOCK_BIT = 6;
    localparam int BW_TRACK_BIT = 5;
    localparam int MULT_LSB = 4;
    localparam int RANGE_LSB = 0;

    // reset values
    localparam logic CTRL_ON_RESET = 1'b1;
    localparam logic [7:0] DIV_RESET = 8'h11;

    // timing counts
    localparam logic [1:0] SWITCH_EDGES = 2'h3;
    localparam logic [7:0] WINDOW_EDGES = 8'h20;
    localparam logic [7:0] LOCK_TOL = 8'h01;
    localparam logic [7:0] UNLOCK_TOL = 8'h02;
    localparam logic [7:0] TRACK_TOL = 8'h02;
    localparam logic [7:0] UNTRACK_TOL = 8'h04;

    typedef enum logic [1:0] {
        SW_RUN = 2'b01,
        SW_HOLD = 2'b10
    } switch_state_e_t;

    typedef struct packed {
        logic lock;
        logic track;
    } lock_status_t;

    typedef struct packed {
        switch_state_e_t state;
        logic [1:0] xcnt;
        logic [1:0] vcnt;
        logic use_vco;
        logic base;
        logic bus;
    } switch_reg_t;

    typedef struct packed {
        logic [3:0] div_cnt;
        logic [7:0] ref_cnt;
        logic [7:0] fb_cnt;
        lock_status_t status;
    } cmp_reg_t;

    typedef struct packed {
        logic ack;
        logic [7:0] dat;
        logic ie;
        logic flag;
        logic on;
        logic sel;
        logic auto_bw;
        logic acq_man;
        logic [7:0] div;
        logic xprev;
        logic vprev;
        logic lock_prev;
        logic irq;
        logic loop_en;
        logic filt_track;
        logic [3:0] mult_eff;
    } top_reg_t;

endpackage

/* hdl/lock_compare.sv */
`timescale 1ns/100ps
`default_nettype none
module lock_compare
    import clock_gen_pkg::*;
#(
    parameter logic [7:0] LOCK_T = LOCK_TOL,
    parameter logic [7:0] UNLOCK_T = UNLOCK_TOL,
    parameter logic [7:0] TRACK_T = TRACK_TOL,
    parameter logic [7:0] UNTRACK_T = UNTRACK_TOL
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic enable,
    input wire logic [3:0] mult,
    input wire logic ref_edge,
    input wire logic fb_edge,
    // result
    output lock_status_t status
);
    cmp_reg_t s_reg;
    cmp_reg_t s_next;

    function automatic logic [7:0] deviation(input logic [7:0] cnt);
        deviation = (cnt >= WINDOW_EDGES) ? 8'(cnt - WINDOW_EDGES) : 8'(WINDOW_EDGES - cnt);
    endfunction

    always_comb
    begin
        logic pulse;
        logic [7:0] fb;
        logic [7:0] dev;
        s_next = s_reg;
        pulse = 1'b0;
        fb = 8'h00;
        dev = 8'h00;
        // feedback divider, modulo the multiplier
        if (fb_edge)
        begin
            if (s_reg.div_cnt >= 4'(mult - 4'h1))
            begin
                s_next.div_cnt = 4'h0;
                pulse = 1'b1;
            end
            else
                s_next.div_cnt = 4'(s_reg.div_cnt + 4'h1);
        end
        fb = 8'(s_reg.fb_cnt + {7'h00, pulse});
        s_next.fb_cnt = fb;
        dev = deviation(fb);
        if (ref_edge)
        begin
            s_next.ref_cnt = 8'(s_reg.ref_cnt + 8'h01);
            if (s_reg.ref_cnt == 8'(WINDOW_EDGES - 8'h01))
            begin
                s_next.ref_cnt = 8'h00;
                s_next.fb_cnt = 8'h00;
                if (dev <= LOCK_T)
                    s_next.status.lock = 1'b1;
                else if (dev > UNLOCK_T)
                    s_next.status.lock = 1'b0;
                if (dev <= TRACK_T)
                    s_next.status.track = 1'b1;
                else if (dev > UNTRACK_T)
                    s_next.status.track = 1'b0;
            end
        end
        if (!enable)
            s_next = '0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign status = s_reg.status;
endmodule
`default_nettype wire

/* hdl/clock_switch.sv */
`timescale 1ns/100ps
`default_nettype none
module clock_switch
    import clock_gen_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // source edges and choice
    input wire logic x_edge,
    input wire logic v_edge,
    input wire logic want_vco,
    input wire logic vco_running,
    // outputs
    output logic base_out,
    output logic bus_out,
    output logic busy
);
    switch_reg_t s_reg;
    switch_reg_t s_next;

    always_comb
    begin
        logic src_edge;
        s_next = s_reg;
        src_edge = s_reg.use_vco ? v_edge : x_edge;
        unique case (s_reg.state)
            SW_RUN:
            begin
                if (want_vco != s_reg.use_vco)
                begin
                    s_next.state = SW_HOLD;
                    s_next.xcnt = 2'h0;
                    s_next.vcnt = 2'h0;
                end
                else if (src_edge)
                begin
                    // halve the source, then halve again for the bus
                    s_next.base = !s_reg.base;
                    if (!s_reg.base)
                        s_next.bus = !s_reg.bus;
                end
            end
            SW_HOLD:
            begin
                // base output stays put while both sources are counted
                if (x_edge && s_reg.xcnt != SWITCH_EDGES)
                    s_next.xcnt = 2'(s_reg.xcnt + 2'h1);
                if (v_edge && s_reg.vcnt != SWITCH_EDGES)
                    s_next.vcnt = 2'(s_reg.vcnt + 2'h1);
                if (s_reg.xcnt == SWITCH_EDGES && (s_reg.vcnt == SWITCH_EDGES || !vco_running))
                begin
                    s_next.state = SW_RUN;
                    s_next.use_vco = want_vco;
                end
            end
            default:
                s_next.state = SW_RUN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.state <= SW_RUN;
        end
        else
            s_reg <= s_next;
    end

    assign base_out = s_reg.base;
    assign bus_out = s_reg.bus;
    assign busy = (s_reg.state == SW_HOLD);
endmodule
`default_nettype wire

/* tb/clock_gen_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module clock_gen_checker
    import clock_gen_pkg::*;
(
    // bus
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // clock and loop
    input wire logic base_clock_out,
    input wire logic bus_clock_out,
    input wire logic switch_busy,
    input wire logic loop_enable,
    input wire logic [3:0] feedback_mult,
    input wire logic [3:0] range_mult
);
    logic d1_reg;
    logic d2_reg;
    // last two base levels, to see a recent base toggle
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            d1_reg <= 1'b0;
            d2_reg <= 1'b0;
        end
        else
        begin
            d1_reg <= base_clock_out;
            d2_reg <= d1_reg;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_held;
        switch_busy ##1 switch_busy;
    endsequence
    chk_ack_answer: assert property (s_req |=> wb_ack_o)
        else $error("request not answered");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_mult_nonzero: assert property (feedback_mult != 4'h0)
        else $error("multiplier of zero passed on");
    chk_range_off: assert property (range_mult == 4'h0 |-> !loop_enable)
        else $error("loop on with range zero");
    chk_hold_static: assert property (s_held |-> $stable(base_clock_out))
        else $error("base clock moved during switch");
    chk_switch_bound: assert property ($rose(switch_busy) |-> ##[1:150] !switch_busy)
        else $error("switch took too long");
    chk_bus_half: assert property ($changed(bus_clock_out) |->
        base_clock_out != d1_reg || d1_reg != d2_reg)
        else $error("bus clock moved without base clock");
endmodule
bind clock_gen clock_gen_checker chk_i (
    .clk(clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .base_clock_out(base_clock_out),
    .bus_clock_out(bus_clock_out),
    .switch_busy(switch_busy),
    .loop_enable(loop_enable),
    .feedback_mult(feedback_mult),
    .range_mult(range_mult)
);
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb import clock_gen_pkg::*;;
    logic clk = 1'b0;
    logic xclk = 1'b0;
    logic vclk = 1'b0;
    logic rst_n, cyc, stb, we, stop_req, ack;
    logic base, bus, busy, loop_en, ftrack, irq;
    logic [7:0] adr, q;
    logic [31:0] wdat, rdat;
    logic [3:0] fmult, rmult;
    logic [3:0] src_cnt = 4'h0;
    int num_errors, n_tests;
    clock_gen dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .crystal_clock(xclk), .vco_clock(vclk),
        .stop_req(stop_req), .base_clock_out(base), .bus_clock_out(bus),
        .switch_busy(busy), .loop_enable(loop_en), .filter_track(ftrack),
        .feedback_mult(fmult), .range_mult(rmult), .loop_irq(irq));
    always #5 clk = ~clk;
    // crystal period 16 cycles, vco four times faster
    always @(posedge clk)
    begin
        src_cnt <= src_cnt + 4'h1;
        xclk <= src_cnt[3];
        vclk <= src_cnt[1];
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: seen %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat[7:0];
        num_errors += int'(n >= 50);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    task automatic settle();
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk(8'(busy), 8'h01);
        while (busy !== 1'b0 && n < 300)
        begin
            @(posedge clk);
            n++;
        end
        num_errors += int'(n >= 300);
    endtask
    task automatic rate(input int eb);
        int nb, nu;
        logic b, u;
        nb = 0;
        nu = 0;
        // align to an edge so the window spans exactly 128 edges
        @(posedge clk);
        #1;
        repeat (128)
        begin
            b = base;
            u = bus;
            @(posedge clk);
            #1;
            nb += int'(base != b);
            nu += int'(bus != u);
        end
        chk(8'(nb), 8'(eb));
        chk(8'(nu), 8'(eb / 2));
    endtask
    task automatic t_reset();
        rd(ADR_CTRL, 8'h2F);
        rd(ADR_BW, 8'h00);
        rd(8'h7C, 8'h00);
        chk({fmult, rmult}, 8'h11);
    endtask
    task automatic t_divider();
        wr(ADR_DIV, 8'h07);
        chk({fmult, rmult}, 8'h17);
        rd(ADR_DIV, 8'h07);
        wr(ADR_DIV, 8'h44);
        chk({fmult, rmult}, 8'h44);
        repeat (64) @(posedge clk);
        wr(ADR_BW, 8'h20);
        chk(8'(ftrack), 8'h01);
        rd(ADR_BW, 8'h20);
        wr(ADR_BW, 8'h00);
        chk(8'(ftrack), 8'h00);
    endtask
    task automatic t_select();
        rate(8);
        wr(ADR_CTRL, 8'h00);
        chk(8'(loop_en), 8'h00);
        wr(ADR_CTRL, 8'h10);
        rd(ADR_CTRL, 8'h0F);
        rd(ADR_BW, 8'h00);
        wr(ADR_CTRL, 8'h30);
        rd(ADR_CTRL, 8'h2F);
        repeat (64) @(posedge clk);
        wr(ADR_BW, 8'h20);
        chk(8'(ftrack), 8'h01);
        repeat (64) @(posedge clk);
        wb(1'b1, ADR_CTRL, 8'h30);
        settle();
        rd(ADR_CTRL, 8'h3F);
        rate(32);
        wr(ADR_CTRL, 8'h00);
        rd(ADR_CTRL, 8'h2F);
        settle();
        wr(ADR_CTRL, 8'h30);
        @(posedge clk);
        stop_req <= 1'b1;
        repeat (2) @(posedge clk);
        stop_req <= 1'b0;
        rd(ADR_CTRL, 8'h2F);
        wr(ADR_CTRL, 8'h30);
        wr(ADR_DIV, 8'h40);
        chk(8'(loop_en), 8'h00);
        rd(ADR_CTRL, 8'h2F);
        wr(ADR_CTRL, 8'h30);
        rd(ADR_CTRL, 8'h2F);
        wr(ADR_DIV, 8'h44);
        repeat (300) @(posedge clk);
    endtask
    task automatic t_auto();
        wr(ADR_BW, 8'h80);
        wr(ADR_CTRL, 8'h80);
        wr(ADR_CTRL, 8'hA0);
        repeat (1800) @(posedge clk);
        #1;
        chk(8'(irq), 8'h01);
        rd(ADR_BW, 8'hE0);
        wr(ADR_BW, 8'h80);
        rd(ADR_BW, 8'hE0);
        rd(ADR_CTRL, 8'hEF);
        repeat (2) @(posedge clk);
        #1;
        chk(8'(irq), 8'h00);
        // loop off in auto: lock falls, flag and request come back
        wr(ADR_CTRL, 8'h80);
        chk(8'(irq), 8'h01);
        wr(ADR_BW, 8'h00);
        chk(8'(ftrack), 8'h00);
        rd(ADR_CTRL, 8'h0F);
        chk(8'(irq), 8'h00);
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        {rst_n, cyc, stb, we, stop_req} = 5'h00;
        adr = 8'h00;
        wdat = 32'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_divider();
        t_select();
        t_auto();
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
